// ==== hw/dpm_regs.svh ====
// Constants for the dual-port memory block: sizes, masks, offsets, fields
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH

`define DPM_ADDR_W        12
`define DPM_DATA_W        9
`define DPM_ROWS          512
`define DPM_ROW_W         9

`define DPM_MASK_X1       9'h001
`define DPM_MASK_X2       9'h003
`define DPM_MASK_X4       9'h00F
`define DPM_MASK_X9       9'h1FF

`define DPM_CFG_OFS       32'h0000_0000
`define DPM_STAT_OFS      32'h0000_0004
`define DPM_EVT_OFS       32'h0000_0008
`define DPM_CNTA_OFS      32'h0000_000C
`define DPM_CNTB_OFS      32'h0000_0010

`define DPM_CFG_A_LSB     0
`define DPM_CFG_B_LSB     4
`define DPM_GRP_PIPE      2
`define DPM_GRP_WMODE     3
`define DPM_CFG_RST       8'h00
`define DPM_STAT_B_LSB    16
`define DPM_CNT_WR_LSB    16
`define DPM_EVT_COLL      0

`endif

// ==== hw/dpm_pkg.sv ====
// Types and address/lane arithmetic for the dual-port memory block
`default_nettype none
`include "dpm_regs.svh"

package dpm_pkg;

    typedef enum logic [1:0] {
        DPM_W4K1   = 2'b00,
        DPM_W2K2   = 2'b01,
        DPM_W1K4   = 2'b10,
        DPM_W512X9 = 2'b11
    } dpm_width_e;

    // Row index from the used low address bits only
    function automatic logic [8:0] dpm_row(input logic [11:0] a, input dpm_width_e w);
        unique case (w)
            DPM_W4K1:   dpm_row = a[11:3];
            DPM_W2K2:   dpm_row = a[10:2];
            DPM_W1K4:   dpm_row = a[9:1];
            DPM_W512X9: dpm_row = a[8:0];
        endcase
    endfunction

    function automatic logic [3:0] dpm_shift(input logic [11:0] a, input dpm_width_e w);
        unique case (w)
            DPM_W4K1:   dpm_shift = {1'b0, a[2:0]};
            DPM_W2K2:   dpm_shift = {1'b0, a[1:0], 1'b0};
            DPM_W1K4:   dpm_shift = {1'b0, a[0], 2'b00};
            DPM_W512X9: dpm_shift = 4'h0;
        endcase
    endfunction

    function automatic logic [8:0] dpm_mask(input dpm_width_e w);
        unique case (w)
            DPM_W4K1:   dpm_mask = `DPM_MASK_X1;
            DPM_W2K2:   dpm_mask = `DPM_MASK_X2;
            DPM_W1K4:   dpm_mask = `DPM_MASK_X4;
            DPM_W512X9: dpm_mask = `DPM_MASK_X9;
        endcase
    endfunction

    function automatic logic [8:0] dpm_extract(input logic [8:0] row, input logic [11:0] a,
                                               input dpm_width_e w);
        dpm_extract = (row >> dpm_shift(a, w)) & dpm_mask(w);
    endfunction

    function automatic logic [8:0] dpm_merge(input logic [8:0] row, input logic [11:0] a,
                                             input dpm_width_e w, input logic [8:0] d);
        dpm_merge = (row & ~(dpm_mask(w) << dpm_shift(a, w)))
                  | ((d & dpm_mask(w)) << dpm_shift(a, w));
    endfunction

    // Clear first, then count; an event in the clearing cycle is kept
    function automatic logic [15:0] dpm_count(input logic [15:0] c, input logic clr,
                                              input logic inc);
        dpm_count = (clr ? 16'h0000 : c) + {15'h0000, inc};
    endfunction

endpackage

`default_nettype wire

// ==== hw/dpm_port_if.sv ====
// Signals between the memory core and one port's output logic
`timescale 1ns/10ps
`default_nettype none

interface dpm_port_if;
    import dpm_pkg::*;
    logic       sel_n;
    logic       rw_n;
    logic [11:0] addr;
    logic [8:0] wdata;
    dpm_width_e width;
    logic       pipe;
    logic       wmode;
    logic [8:0] row;
    logic [8:0] rdata;

    modport port (input sel_n, rw_n, addr, wdata, width, pipe, wmode, row, output rdata);
    modport core (output sel_n, rw_n, addr, wdata, width, pipe, wmode, row, input rdata);
endinterface

`default_nettype wire

// ==== hw/dpm_port_out.sv ====
// Read data path of one memory port: flow-through, pipeline and write output
`timescale 1ns/10ps
`default_nettype none

module dpm_port_out (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Port signals
    dpm_port_if.port  io
);
    import dpm_pkg::*;

    logic [8:0] rd_val;
    logic [8:0] wr_val;
    logic [8:0] flow_q;
    logic [8:0] pipe_q;
    logic       rd;
    logic       wr;

    assign rd     = !io.sel_n && io.rw_n;
    assign wr     = !io.sel_n && !io.rw_n;
    assign rd_val = dpm_extract(io.row, io.addr, io.width);
    assign wr_val = io.wdata & dpm_mask(io.width);

    // Flow-through stage; holds when deselected or on a plain write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flow_q <= 9'h000;
        end else if (rd) begin
            flow_q <= rd_val;
        end else if (wr && io.wmode) begin
            flow_q <= wr_val;
        end
    end

    // Output register stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pipe_q <= 9'h000;
        end else begin
            pipe_q <= flow_q;
        end
    end

    assign io.rdata = io.pipe ? pipe_q : flow_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_FLOW_READ: assert property (rd && !io.pipe |=> io.rdata == $past(rd_val))
        else $error("flow-through read data wrong");
    AST_PIPE_READ: assert property (rd && io.pipe ##1 io.pipe |=> io.rdata == $past(rd_val, 2))
        else $error("pipelined read data not one cycle later");
    AST_DESEL_HOLD: assert property (io.sel_n && !io.pipe |=> $stable(io.rdata))
        else $error("output changed while deselected");
    AST_WRITE_HOLD: assert property (wr && !io.wmode && !io.pipe |=> $stable(io.rdata))
        else $error("output changed on write with hold mode");
    AST_WRITE_THRU: assert property (wr && io.wmode && !io.pipe |=> io.rdata == $past(wr_val))
        else $error("write data not passed through");
    AST_READ_OVERRIDE: assert property (rd && io.wmode |=> flow_q == $past(rd_val))
        else $error("write mode affected a read");

    COV_PIPE_READ: cover property (rd && io.pipe ##2 io.rdata != 9'h000);
    COV_WRITE_THRU: cover property (wr && io.wmode ##1 rd);
endmodule

`default_nettype wire

// ==== hw/dpm_top.sv ====
// Dual-port 4608-bit memory with AHB-Lite configuration and status registers
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

`include "dpm_regs.svh"

// How it works
// - Width setting picks 4kx1, 2kx2, 1kx4, 512x9
// - Port works only while select is low
// - Deselected port output keeps last value
// - Write enable low writes, high reads
// - Port accesses are synchronous to port clock
// - Pipeline off: read data right after read
// - Pipeline on: read data one cycle later
// - Hold mode: write keeps last read data
// - Write-through mode: write shows written data
// - Write-output mode ignored during reads
// - Reset zeroes outputs, blocks access, clears holds
// - Reset leaves stored contents unchanged
// - Each port has 12-bit address
// - Only organisation's low address bits decoded
module dpm_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Memory port A
    input  wire logic        port_a_select_n,
    input  wire logic        port_a_read_write_n,
    input  wire logic [11:0] port_a_address,
    input  wire logic [8:0]  port_a_wdata,
    output logic [8:0]       port_a_rdata,
    // Memory port B
    input  wire logic        port_b_select_n,
    input  wire logic        port_b_read_write_n,
    input  wire logic [11:0] port_b_address,
    input  wire logic [8:0]  port_b_wdata,
    output logic [8:0]       port_b_rdata
);
    import dpm_pkg::*;

    dpm_port_if pa ();
    dpm_port_if pb ();

    logic [8:0]  mem [`DPM_ROWS];
    logic [7:0]  cfg_q;
    logic        evt_q;
    logic [31:0] cnt_a_q;
    logic [31:0] cnt_b_q;
    logic [31:0] hrdata_q;
    logic        wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [31:0] rd_mux;
    logic        ap_valid;
    logic        cfg_we;
    logic        evt_we;
    logic        cnta_we;
    logic        cntb_we;
    logic [8:0]  ra;
    logic [8:0]  rb;
    logic        wa;
    logic        wb;
    logic        rda;
    logic        rdb;
    logic        coll;
    logic [8:0]  merge_a;
    logic [8:0]  row_b_base;

    // Port A configuration and pins
    assign pa.sel_n = port_a_select_n;
    assign pa.rw_n  = port_a_read_write_n;
    assign pa.addr  = port_a_address;
    assign pa.wdata = port_a_wdata;
    assign pa.width = dpm_width_e'(cfg_q[`DPM_CFG_A_LSB +: 2]);
    assign pa.pipe  = cfg_q[`DPM_CFG_A_LSB + `DPM_GRP_PIPE];
    assign pa.wmode = cfg_q[`DPM_CFG_A_LSB + `DPM_GRP_WMODE];
    assign pa.row   = mem[ra];
    assign port_a_rdata = pa.rdata;

    // Port B configuration and pins
    assign pb.sel_n = port_b_select_n;
    assign pb.rw_n  = port_b_read_write_n;
    assign pb.addr  = port_b_address;
    assign pb.wdata = port_b_wdata;
    assign pb.width = dpm_width_e'(cfg_q[`DPM_CFG_B_LSB +: 2]);
    assign pb.pipe  = cfg_q[`DPM_CFG_B_LSB + `DPM_GRP_PIPE];
    assign pb.wmode = cfg_q[`DPM_CFG_B_LSB + `DPM_GRP_WMODE];
    assign pb.row   = mem[rb];
    assign port_b_rdata = pb.rdata;

    // Row decode from used address bits
    assign ra = dpm_row(port_a_address, pa.width);
    assign rb = dpm_row(port_b_address, pb.width);

    // Access qualifiers; reset blocks every access
    assign wa  = nrst && !port_a_select_n && !port_a_read_write_n;
    assign wb  = nrst && !port_b_select_n && !port_b_read_write_n;
    assign rda = nrst && !port_a_select_n && port_a_read_write_n;
    assign rdb = nrst && !port_b_select_n && port_b_read_write_n;

    // Same-row writes: B's lanes land on top of A's
    assign coll       = wa && wb && (ra == rb);
    assign merge_a    = dpm_merge(mem[ra], port_a_address, pa.width, port_a_wdata);
    assign row_b_base = coll ? merge_a : mem[rb];

    // Output logic of each port
    dpm_port_out u_port_a (
        .clk  (clk),
        .nrst (nrst),
        .io   (pa.port)
    );

    dpm_port_out u_port_b (
        .clk  (clk),
        .nrst (nrst),
        .io   (pb.port)
    );

    // Storage array, never touched by reset
    always_ff @(posedge clk) begin
        if (wa) begin
            mem[ra] <= merge_a;
        end
        if (wb) begin
            mem[rb] <= dpm_merge(row_b_base, port_b_address, pb.width, port_b_wdata);
        end
    end

    // AHB-Lite address phase
    assign ap_valid = hsel && hready && htrans[1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= ap_valid && hwrite;
            if (ap_valid) begin
                wr_addr_q <= haddr;
            end
        end
    end

    // Data phase write strobes
    assign cfg_we  = wr_pend_q && (wr_addr_q == `DPM_CFG_OFS);
    assign evt_we  = wr_pend_q && (wr_addr_q == `DPM_EVT_OFS);
    assign cnta_we = wr_pend_q && (wr_addr_q == `DPM_CNTA_OFS);
    assign cntb_we = wr_pend_q && (wr_addr_q == `DPM_CNTB_OFS);

    // Configuration register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `DPM_CFG_RST;
        end else if (cfg_we) begin
            cfg_q <= hwdata[7:0];
        end
    end

    // Collision flag, write one to clear, set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evt_q <= 1'b0;
        end else if (coll) begin
            evt_q <= 1'b1;
        end else if (evt_we && hwdata[`DPM_EVT_COLL]) begin
            evt_q <= 1'b0;
        end
    end

    // Access counters, any write clears
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_a_q <= 32'h0000_0000;
        end else begin
            cnt_a_q[15:0]  <= dpm_count(cnt_a_q[15:0], cnta_we, rda);
            cnt_a_q[31:16] <= dpm_count(cnt_a_q[31:16], cnta_we, wa);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_b_q <= 32'h0000_0000;
        end else begin
            cnt_b_q[15:0]  <= dpm_count(cnt_b_q[15:0], cntb_we, rdb);
            cnt_b_q[31:16] <= dpm_count(cnt_b_q[31:16], cntb_we, wb);
        end
    end

    // Read data selection; unmapped reads as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            `DPM_CFG_OFS: begin
                rd_mux[7:0] = cfg_q;
            end
            `DPM_STAT_OFS: begin
                rd_mux[8:0] = port_a_rdata;
                rd_mux[`DPM_STAT_B_LSB +: 9] = port_b_rdata;
            end
            `DPM_EVT_OFS: begin
                rd_mux[`DPM_EVT_COLL] = evt_q;
            end
            `DPM_CNTA_OFS: begin
                rd_mux = cnt_a_q;
            end
            `DPM_CNTB_OFS: begin
                rd_mux = cnt_b_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_RESET_ZERO: assert property (
        @(posedge clk) disable iff (1'b0)
        !nrst |-> (port_a_rdata == 9'h000) && (port_b_rdata == 9'h000))
        else $error("outputs not zero in reset");
    AST_RESET_KEEP: assert property (
        @(posedge clk) disable iff (1'b0)
        !nrst |=> mem[$past(ra)] === $past(pa.row))
        else $error("stored row changed during reset");
    AST_MEM_WRITE: assert property (
        wa && !wb |=> dpm_extract(mem[$past(ra)], $past(port_a_address), $past(pa.width))
                      == ($past(port_a_wdata) & dpm_mask($past(pa.width))))
        else $error("port A write not stored");
    AST_NO_DESEL_WRITE: assert property (
        port_b_select_n && !wa |=> mem[$past(rb)] === $past(pb.row))
        else $error("deselected port changed memory");
    AST_COLL_SET: assert property (coll |=> evt_q && cnt_a_q[31:16] != 16'h0000)
        else $error("collision flag not set");

    COV_COLLISION: cover property (coll);
    COV_RESET_MID: cover property (@(posedge clk) disable iff (1'b0) wa ##1 !nrst);
endmodule

`default_nettype wire

// ==== tb/dpm_fabric_port.sv ====
// Behavioural user logic that drives one memory port
`timescale 1ns/10ps
`default_nettype none

module dpm_fabric_port (
    // Clock
    input  wire logic   clk,
    // Port drive
    output logic        select_n,
    output logic        read_write_n,
    output logic [11:0] address,
    output logic [8:0]  wdata
);
    initial begin
        select_n = 1'b1;
        read_write_n = 1'b1;
        address = 12'h000;
        wdata = 9'h000;
    end

    // One access at the next edge, then release the lines
    task automatic op(input logic sel_n, input logic rw_n, input logic [11:0] a,
                      input logic [8:0] d, input logic [1:0] w);
        @(posedge clk);
        select_n     <= sel_n;
        read_write_n <= rw_n;
        address      <= a & (12'hFFF >> w);
        wdata        <= d;
        @(posedge clk);
        // Released address and data show inverted values; read_write_n keeps its last value
        select_n <= 1'b1;
        address  <= ~a;
        wdata    <= ~d;
    endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the dual-port memory block
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("unexpected at %0t ns: got %0h, expected %0h", $time, got, exp); \
        end \
    end

module testbench;
    logic        clk;
    logic        nrst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        a_sel_n;
    logic        a_rw_n;
    logic [11:0] a_addr;
    logic [8:0]  a_wdata;
    logic [8:0]  a_rdata;
    logic        b_sel_n;
    logic        b_rw_n;
    logic [11:0] b_addr;
    logic [8:0]  b_wdata;
    logic [8:0]  b_rdata;
    int          failures;
    int          checks_done;
    logic [11:0] addr_tab [4] = '{12'd41, 12'd21, 12'd11, 12'd5};
    logic [8:0]  exp_tab [4] = '{9'h000, 9'h001, 9'h00A, 9'h1A5};

    dpm_top dpm_top_inst (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .port_a_select_n(a_sel_n), .port_a_read_write_n(a_rw_n),
        .port_a_address(a_addr), .port_a_wdata(a_wdata), .port_a_rdata(a_rdata),
        .port_b_select_n(b_sel_n), .port_b_read_write_n(b_rw_n),
        .port_b_address(b_addr), .port_b_wdata(b_wdata), .port_b_rdata(b_rdata)
    );

    dpm_fabric_port dpm_fabric_port_inst (
        .clk(clk), .select_n(a_sel_n), .read_write_n(a_rw_n),
        .address(a_addr), .wdata(a_wdata)
    );

    dpm_fabric_port dpm_fabric_port_inst_b (
        .clk(clk), .select_n(b_sel_n), .read_write_n(b_rw_n),
        .address(b_addr), .wdata(b_wdata)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Single word transfer; read data taken at the end of the data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, q);
        `CHK(q, exp)
    endtask

    task automatic tend(input string n);
        $display("test %s finished", n);
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #20000;
        failures++;
        test_done;
    end

    initial begin
        nrst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        failures = 0;
        checks_done = 0;
        #1 nrst = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0020, 32'h0000_0000);
        tend("reset");
        wr(32'h0000_0000, 32'h0000_00F3);
        rd(32'h0000_0000, 32'h0000_00F3);
        dpm_fabric_port_inst.op(1'b0, 1'b0, 12'h005, 9'h1A5, 2'd3);
        #1 `CHK(a_rdata, 9'h000)
        dpm_fabric_port_inst.op(1'b0, 1'b1, 12'h005, 9'h000, 2'd3);
        #1 `CHK(a_rdata, 9'h1A5)
        dpm_fabric_port_inst.op(1'b1, 1'b0, 12'h005, 9'h000, 2'd3);
        #1 `CHK(a_rdata, 9'h1A5)
        dpm_fabric_port_inst.op(1'b0, 1'b1, 12'h005, 9'h000, 2'd3);
        #1 `CHK(a_rdata, 9'h1A5)
        tend("port a");
        dpm_fabric_port_inst_b.op(1'b0, 1'b0, 12'h007, 9'h0C3, 2'd3);
        #1 `CHK(b_rdata, 9'h000)
        @(posedge clk);
        #1 `CHK(b_rdata, 9'h0C3)
        dpm_fabric_port_inst_b.op(1'b0, 1'b1, 12'h005, 9'h000, 2'd3);
        #1 `CHK(b_rdata, 9'h0C3)
        @(posedge clk);
        #1 `CHK(b_rdata, 9'h1A5)
        repeat (3) @(posedge clk);
        #1 `CHK(b_rdata, 9'h1A5)
        tend("port b");
        for (int w = 0; w < 4; w++) begin
            wr(32'h0000_0000, {24'h00_0000, 4'hF, 2'b00, w[1:0]});
            dpm_fabric_port_inst.op(1'b0, 1'b1, addr_tab[w], 9'h000, w[1:0]);
            #1 `CHK(a_rdata, exp_tab[w])
        end
        tend("widths");
        @(posedge clk);
        nrst <= 1'b0;
        #1 `CHK(a_rdata, 9'h000)
        `CHK(b_rdata, 9'h000)
        `CHK(hrdata, 32'h0000_0000)
        `CHK(hresp, 1'b0)
        dpm_fabric_port_inst.op(1'b0, 1'b0, 12'h005, 9'h0FF, 2'd3);
        @(posedge clk);
        nrst <= 1'b1;
        wr(32'h0000_0000, 32'h0000_000B);
        dpm_fabric_port_inst.op(1'b0, 1'b1, 12'h005, 9'h000, 2'd3);
        #1 `CHK(a_rdata, 9'h1A5)
        rd(32'h0000_0004, 32'h0000_01A5);
        tend("reset in run");
        fork
            dpm_fabric_port_inst.op(1'b0, 1'b0, 12'h009, 9'h0F0, 2'd3);
            dpm_fabric_port_inst_b.op(1'b0, 1'b0, 12'h048, 9'h001, 2'd0);
        join
        #1 `CHK(a_rdata, 9'h0F0)
        rd(32'h0000_0008, 32'h0000_0001);
        wr(32'h0000_0008, 32'h0000_0001);
        rd(32'h0000_0008, 32'h0000_0000);
        dpm_fabric_port_inst.op(1'b0, 1'b1, 12'h009, 9'h000, 2'd3);
        #1 `CHK(a_rdata, 9'h0F1)
        rd(32'h0000_000C, 32'h0001_0002);
        rd(32'h0000_0010, 32'h0001_0000);
        tend("collision");
        test_done;
    end
endmodule

`default_nettype wire
